// ### inc/acfc_pkg.sv
// Shared constants, types and helpers of the audio port frame clock control
package acfc_pkg;

  // Register offsets
  localparam logic [7:0] ACFC_ADDR_PRI_HI = 8'h38;
  localparam logic [7:0] ACFC_ADDR_PRI_LO = 8'h39;
  localparam logic [7:0] ACFC_ADDR_SEC_HI = 8'h3A;
  localparam logic [7:0] ACFC_ADDR_SEC_LO = 8'h3B;
  localparam logic [7:0] ACFC_ADDR_ERR_A = 8'h3C;
  localparam logic [7:0] ACFC_ADDR_ERR_B = 8'h3D;

  // Reset value of every register in the block
  localparam logic [7:0] ACFC_REG_RESET = 8'h00;

  // Field positions of the clock configuration upper registers
  localparam int ACFC_BIT_INT_SEL = 7;
  localparam int ACFC_BIT_INV = 6;
  localparam int ACFC_UPPER_MSB = 5;

  // Field positions of the first clock error register
  localparam int ACFC_ERR_DSP = 7;
  localparam int ACFC_ERR_SRC = 4;
  localparam int ACFC_ERR_DEM = 3;
  localparam int ACFC_ERR_PDM = 2;
  localparam int ACFC_ERR_STOP = 1;

  // Ratio width and the smallest ratio a frame can be built from
  localparam int ACFC_RATIO_W = 14;
  localparam logic [13:0] ACFC_MIN_RATIO = 14'h0002;

  // Timing
  localparam int ACFC_MCLK_HZ = 200_000_000;
  localparam int ACFC_STOP_TIME_MS = 1;
  localparam int ACFC_STOP_CYCLES = ACFC_STOP_TIME_MS * (ACFC_MCLK_HZ / 1000);
  // Half period of the internal bit clock, in mclk cycles
  localparam int ACFC_INT_DIV = 2;

  // Register port request, one access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acfc_reg_req_t;

  // Conditions reported by the surrounding clock tree
  typedef struct packed {
    logic custom_ratio;
    logic resampler_ratio_error;
    logic element_matching_rate_error;
    logic pdm_clock_gen_error;
    logic ratio_mismatch;
  } acfc_err_in_t;

  // Decoded per-port controller configuration
  typedef struct packed {
    logic ctrl;
    logic int_sel;
    logic inv;
    logic [13:0] ratio;
  } acfc_port_cfg_t;

  // Word handed to the link domain
  typedef struct packed {
    logic active;
    logic inv;
    logic [13:0] ratio;
  } acfc_link_cfg_t;

  // Bit clock count inside a frame, wrapping after ratio counts
  function automatic logic [13:0] acfc_next_count(input logic [13:0] cnt,
                                                  input logic [13:0] ratio);
    logic [13:0] last;
    last = ratio - 14'h0001;
    acfc_next_count = (cnt >= last) ? 14'h0000 : cnt + 14'h0001;
  endfunction

endpackage

// ### rtl/acfc_link_fsync.sv
// Frame sync generator running on an externally supplied bit clock
module acfc_link_fsync (
  // Link bit clock
  input wire logic lclk,
  // Reset from the register clock domain
  input wire logic rst,
  // Configuration handshake
  input wire acfc_pkg::acfc_link_cfg_t cfg_word,
  input wire logic cfg_req,
  output logic cfg_ack,
  // Frame sync
  output logic fsync
);
  import acfc_pkg::*;

  typedef struct packed {
    logic [2:0] rst_sy;
    logic rst_f;
    logic [2:0] req_sy;
    acfc_link_cfg_t cfg;
    logic ack;
    logic [13:0] cnt;
    logic fs;
  } acfc_link_st_t;

  acfc_link_st_t q;
  acfc_link_st_t d;
  logic fs_neg_q;

  always_comb begin
    d = q;
    d.rst_sy = {q.rst_sy[1:0], rst};
    // Reset from the other domain counts once stages two and three agree
    if (q.rst_sy[1] == q.rst_sy[2]) begin
      d.rst_f = q.rst_sy[2];
    end
    d.req_sy = {q.req_sy[1:0], cfg_req};
    if (q.rst_f) begin
      d.req_sy = '0;
      d.cfg = '0;
      d.ack = 1'b0;
      d.cnt = 14'h0000;
      d.fs = 1'b0;
    end else begin
      // Word is held stable by the sender until the ack toggle returns;
      // a toggle counts once stages two and three agree
      if (q.req_sy[1] == q.req_sy[2] && q.req_sy[2] != q.ack) begin
        d.cfg = cfg_word;
        d.ack = q.req_sy[2];
      end
      if (!q.cfg.active) begin
        d.cnt = 14'h0000;
        d.fs = 1'b0;
      end else begin
        d.cnt = acfc_next_count(q.cnt, q.cfg.ratio); // [RULE15]
        d.fs = (d.cnt == 14'h0000);
      end
    end
  end

  always_ff @(posedge lclk) begin
    q <= d;
  end

  // Falling-edge copy launches sync on the opposite clock edge
  always_ff @(negedge lclk) begin
    fs_neg_q <= q.fs;
  end

  assign cfg_ack = q.ack;
  assign fsync = q.cfg.inv ? fs_neg_q : q.fs; // [RULE2] [RULE5]

endmodule

// ### rtl/acfc_frame_clock_ctrl.sv
// Audio port frame clock control: config registers, sync gen, clock errors
//
// Function
// (RULE1) Primary sync uses internal bit clock when select is 1, else external.
// (RULE2) Primary invert bit flips bit clock polarity only for sync generation.
// (RULE3) Primary ratio: upper six bits at 0x38, lower byte at 0x39.
// (RULE4) Secondary sync uses internal bit clock when select is 1, else external.
// (RULE5) Secondary invert bit flips bit clock polarity only for its sync.
// (RULE6) Secondary ratio: upper six bits at 0x3A, lower byte at 0x3B.
// (RULE7) Status bit 7 shows an invalid sync to clock source ratio.
// (RULE8) Status bit 4 shows an unsupported resampler ratio, not for custom.
// (RULE9) Status bit 3 shows no valid element matching rate.
// (RULE10) Status bit 2 shows no valid PDM clock; clears when possible.
// (RULE11) Status bit 1 shows audio clock source stopped at least 1 ms.
// (RULE12) Reserved status bits 6, 5, 0 are written zero and read zero.
// (RULE13) All these registers reset to zero.
// (RULE14) Controller select 1 drives bit clock and sync; 0 receives them.
// (RULE15) Ratio is upper part over lower byte; that many clocks per frame.
module acfc_frame_clock_ctrl #(
  parameter int STOP_CYCLES = acfc_pkg::ACFC_STOP_CYCLES,
  parameter int INT_DIV = acfc_pkg::ACFC_INT_DIV
) (
  // Register clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link bit clocks from the far end
  input wire logic pri_bclk,
  input wire logic sec_bclk,
  // Register port
  input wire acfc_pkg::acfc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Controller selects and clock tree conditions
  input wire logic primary_controller_select,
  input wire logic secondary_controller_select,
  input wire acfc_pkg::acfc_err_in_t err_in,
  // Audio clock source pin
  input wire logic aclk_src,
  // Internal bit clocks driven out
  output logic pri_bclk_int_o,
  output logic sec_bclk_int_o,
  // Frame syncs, one per clock source
  output logic pri_fsync_int_o,
  output logic sec_fsync_int_o,
  output logic pri_fsync_ext_o,
  output logic sec_fsync_ext_o
);
  import acfc_pkg::*;

  localparam int SW = $clog2(STOP_CYCLES + 1);
  localparam int DW = (INT_DIV > 1) ? $clog2(INT_DIV) : 1;
  localparam logic [SW-1:0] STOP_LAST = SW'(STOP_CYCLES);
  localparam logic [DW-1:0] DIV_LAST = DW'(INT_DIV - 1);

  // Elaboration refuses a stop time or divider the counters cannot serve
  if (STOP_CYCLES < 2 || INT_DIV < 1) begin : g_param_check
    $error("acfc_frame_clock_ctrl: STOP_CYCLES >= 2, INT_DIV >= 1");
  end

  typedef struct packed {
    logic [7:0] pri_hi;
    logic [7:0] pri_lo;
    logic [7:0] sec_hi;
    logic [7:0] sec_lo;
    logic [7:0] rdata;
    logic rvalid;
    logic [2:0] aclk_sy;
    logic aclk_filt;
    logic [SW-1:0] stop_cnt;
    logic [7:0] err_a;
    logic [DW-1:0] div_cnt;
    logic bclk_int;
    logic [1:0][13:0] fcnt;
    logic [1:0] fs_int;
    logic [1:0] bclk_out;
    logic [1:0][15:0] xword;
    logic [1:0] xreq;
    logic [1:0] ack_s1;
    logic [1:0] ack_s2;
    logic [1:0] ack_s3;
  } acfc_main_st_t;

  acfc_main_st_t q;
  acfc_main_st_t d;
  acfc_port_cfg_t cfg [2];
  logic [1:0] ack_in;
  logic aclk_edge;
  logic div_wrap;

  function automatic acfc_port_cfg_t port_cfg(input logic [7:0] hi,
                                              input logic [7:0] lo,
                                              input logic ctrl);
    acfc_port_cfg_t c;
    c.ctrl = ctrl;
    c.int_sel = hi[ACFC_BIT_INT_SEL];
    c.inv = hi[ACFC_BIT_INV];
    c.ratio = {hi[ACFC_UPPER_MSB:0], lo}; // [RULE15]
    port_cfg = c;
  endfunction

  always_comb begin
    cfg[0] = port_cfg(q.pri_hi, q.pri_lo, primary_controller_select);
    cfg[1] = port_cfg(q.sec_hi, q.sec_lo, secondary_controller_select);
  end

  always_comb begin
    acfc_link_cfg_t lw;
    logic ev;
    logic bad_ratio;
    lw = '0;
    ev = 1'b0;
    bad_ratio = 1'b0;
    d = q;
    d.rvalid = 1'b0;

    // Register writes; status offsets are read-only and ignore writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        ACFC_ADDR_PRI_HI: d.pri_hi = reg_req.wdata; // [RULE3]
        ACFC_ADDR_PRI_LO: d.pri_lo = reg_req.wdata; // [RULE3]
        ACFC_ADDR_SEC_HI: d.sec_hi = reg_req.wdata; // [RULE6]
        ACFC_ADDR_SEC_LO: d.sec_lo = reg_req.wdata; // [RULE6]
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      d.rvalid = 1'b1;
      unique case (reg_req.addr)
        ACFC_ADDR_PRI_HI: d.rdata = q.pri_hi;
        ACFC_ADDR_PRI_LO: d.rdata = q.pri_lo;
        ACFC_ADDR_SEC_HI: d.rdata = q.sec_hi;
        ACFC_ADDR_SEC_LO: d.rdata = q.sec_lo;
        ACFC_ADDR_ERR_A: d.rdata = q.err_a;
        default: d.rdata = 8'h00;
      endcase
    end

    // Audio clock source: a level change counts once stages two and three
    // agree, which filters a single-sample glitch
    d.aclk_sy = {q.aclk_sy[1:0], aclk_src};
    aclk_edge = (q.aclk_sy[1] == q.aclk_sy[2]) &&
                (q.aclk_sy[2] != q.aclk_filt);
    if (q.aclk_sy[1] == q.aclk_sy[2]) begin
      d.aclk_filt = q.aclk_sy[2];
    end
    if (aclk_edge) begin
      d.stop_cnt = '0;
    end else if (q.stop_cnt != STOP_LAST) begin
      d.stop_cnt = q.stop_cnt + SW'(1);
    end

    // Internal bit clock divider, shared by both ports
    div_wrap = (q.div_cnt == DIV_LAST);
    if (div_wrap) begin
      d.div_cnt = '0;
      d.bclk_int = ~q.bclk_int;
    end else begin
      d.div_cnt = q.div_cnt + DW'(1);
    end

    for (int p = 0; p < 2; p++) begin
      // Inversion only moves the counting edge; the bit clock driven out
      // keeps its own polarity
      ev = div_wrap && (cfg[p].inv ? q.bclk_int : !q.bclk_int); // [RULE2] [RULE5]
      if (!(cfg[p].ctrl && cfg[p].int_sel) ||
          cfg[p].ratio == 14'h0000) begin // [RULE1] [RULE4] [RULE14]
        d.fcnt[p] = 14'h0000;
        d.fs_int[p] = 1'b0;
      end else if (ev) begin
        d.fcnt[p] = acfc_next_count(q.fcnt[p], cfg[p].ratio); // [RULE15]
        d.fs_int[p] = (d.fcnt[p] == 14'h0000);
      end
      d.bclk_out[p] = cfg[p].ctrl && cfg[p].int_sel && d.bclk_int; // [RULE14]
      if (cfg[p].ctrl && cfg[p].ratio < ACFC_MIN_RATIO) begin
        bad_ratio = 1'b1;
      end

      // External source: hand the word over only when the last one is acked
      lw.active = cfg[p].ctrl && !cfg[p].int_sel &&
                  cfg[p].ratio != 14'h0000; // [RULE1] [RULE4] [RULE14]
      lw.inv = cfg[p].inv;
      lw.ratio = cfg[p].ratio;
      // The returned ack counts once stages two and three agree, so a
      // metastable sample never releases the word early
      if (q.ack_s2[p] == q.ack_s3[p] && q.ack_s3[p] == q.xreq[p] &&
          q.xword[p] != lw) begin
        d.xword[p] = lw;
        d.xreq[p] = ~q.xreq[p];
      end
    end
    d.ack_s1 = ack_in;
    d.ack_s2 = q.ack_s1;
    d.ack_s3 = q.ack_s2;

    // Status mirrors live conditions; reserved bits stay zero
    d.err_a = 8'h00; // [RULE12]
    d.err_a[ACFC_ERR_DSP] = bad_ratio || err_in.ratio_mismatch; // [RULE7]
    d.err_a[ACFC_ERR_SRC] = err_in.resampler_ratio_error &&
                            !err_in.custom_ratio; // [RULE8]
    d.err_a[ACFC_ERR_DEM] = err_in.element_matching_rate_error; // [RULE9]
    d.err_a[ACFC_ERR_PDM] = err_in.pdm_clock_gen_error; // [RULE10]
    d.err_a[ACFC_ERR_STOP] = (d.stop_cnt == STOP_LAST); // [RULE11]
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0; // [RULE13]
    end else begin
      q <= d;
    end
  end

  acfc_link_fsync u_pri_link (
    .lclk(pri_bclk),
    .rst(rst),
    .cfg_word(acfc_link_cfg_t'(q.xword[0])),
    .cfg_req(q.xreq[0]),
    .cfg_ack(ack_in[0]),
    .fsync(pri_fsync_ext_o)
  );

  acfc_link_fsync u_sec_link (
    .lclk(sec_bclk),
    .rst(rst),
    .cfg_word(acfc_link_cfg_t'(q.xword[1])),
    .cfg_req(q.xreq[1]),
    .cfg_ack(ack_in[1]),
    .fsync(sec_fsync_ext_o)
  );

  assign reg_rdata = q.rdata;
  assign reg_rvalid = q.rvalid;
  assign pri_bclk_int_o = q.bclk_out[0];
  assign sec_bclk_int_o = q.bclk_out[1];
  assign pri_fsync_int_o = q.fs_int[0];
  assign sec_fsync_int_o = q.fs_int[1];

  default clocking acfc_cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  AST_PRI_EXT_SRC: assert property ( // [RULE1]
    !cfg[0].int_sel |=> !pri_fsync_int_o && !pri_bclk_int_o)
    else $error("primary internal sync active with external source");

  AST_SEC_EXT_SRC: assert property ( // [RULE4]
    !cfg[1].int_sel |=> !sec_fsync_int_o && !sec_bclk_int_o)
    else $error("secondary internal sync active with external source");

  AST_PRI_INV_EDGE: assert property ( // [RULE2]
    $rose(pri_fsync_int_o) |-> ($past(cfg[0].inv) != q.bclk_int))
    else $error("primary sync launched on the wrong bit clock edge");

  AST_SEC_INV_EDGE: assert property ( // [RULE5]
    $rose(sec_fsync_int_o) |-> ($past(cfg[1].inv) != q.bclk_int))
    else $error("secondary sync launched on the wrong bit clock edge");

  AST_PRI_RATIO_REG: assert property ( // [RULE3]
    reg_req.wr && reg_req.addr == ACFC_ADDR_PRI_LO
    |=> q.pri_lo == $past(reg_req.wdata))
    else $error("primary ratio lower byte not stored");

  AST_SEC_RATIO_REG: assert property ( // [RULE6]
    reg_req.rd && reg_req.addr == ACFC_ADDR_SEC_HI
    |=> reg_rvalid && reg_rdata == $past(q.sec_hi))
    else $error("secondary upper register does not read back");

  AST_DSP_ERR: assert property ( // [RULE7]
    cfg[0].ctrl && cfg[0].ratio < ACFC_MIN_RATIO |=> q.err_a[ACFC_ERR_DSP])
    else $error("invalid primary ratio not flagged");

  AST_SRC_ERR: assert property ( // [RULE8]
    err_in.custom_ratio |=> !q.err_a[ACFC_ERR_SRC])
    else $error("resampler ratio flagged under custom ratio");

  AST_DEM_ERR: assert property ( // [RULE9]
    err_in.element_matching_rate_error |=> q.err_a[ACFC_ERR_DEM])
    else $error("element matching rate error not flagged");

  AST_PDM_ERR: assert property ( // [RULE10]
    !err_in.pdm_clock_gen_error |=> !q.err_a[ACFC_ERR_PDM])
    else $error("PDM clock error not cleared");

  AST_STOP_FLAG: assert property ( // [RULE11]
    q.stop_cnt == STOP_LAST - SW'(1) && !aclk_edge
    |=> q.err_a[ACFC_ERR_STOP] ##1 (q.err_a[ACFC_ERR_STOP] || !aclk_edge))
    else $error("stopped audio clock not flagged after the stop time");

  AST_STOP_CLEAR: assert property ( // [RULE11]
    aclk_edge |=> !q.err_a[ACFC_ERR_STOP] && q.stop_cnt == '0)
    else $error("stop flag survives an audio clock edge");

  AST_RSVD_ZERO: assert property ( // [RULE12]
    q.err_a[6:5] == 2'b00 && !q.err_a[0])
    else $error("reserved status bits not zero");

  AST_RESET_ZERO: assert property (@(posedge mclk) // [RULE13]
    $past(rst) |-> q.pri_hi == ACFC_REG_RESET && q.sec_lo == ACFC_REG_RESET
    && q.err_a == ACFC_REG_RESET)
    else $error("register not zero after reset");

  AST_TARGET_QUIET: assert property ( // [RULE14]
    !primary_controller_select ##1 !primary_controller_select
    |=> !pri_fsync_int_o && !pri_bclk_int_o)
    else $error("primary drives clocks in target mode");

  AST_FRAME_WRAP: assert property ( // [RULE15]
    $rose(pri_fsync_int_o) |-> q.fcnt[0] == 14'h0000 &&
    $past(q.fcnt[0]) == $past(cfg[0].ratio) - 14'h0001)
    else $error("primary frame not ratio bit clocks long");

  // Register access, the configuration handover and secondary target mode
  AST_PRI_HI_REG: assert property ( // [RULE3]
    reg_req.wr && reg_req.addr == ACFC_ADDR_PRI_HI
    |=> q.pri_hi == $past(reg_req.wdata))
    else $error("primary upper register not stored");

  AST_SEC_LO_REG: assert property ( // [RULE6]
    reg_req.wr && reg_req.addr == ACFC_ADDR_SEC_LO
    |=> q.sec_lo == $past(reg_req.wdata))
    else $error("secondary ratio lower byte not stored");

  AST_READ_ANSWER: assert property ( // [RULE3]
    reg_req.rd |=> reg_rvalid)
    else $error("read not answered in the next cycle");

  AST_READ_QUIET: assert property ( // [RULE3]
    !reg_req.rd |=> !reg_rvalid)
    else $error("read answer without a read");

  AST_HANDOVER_WAIT: assert property ( // [RULE1]
    $changed(q.xreq[0]) |-> $past(q.ack_s3[0]) == $past(q.xreq[0]))
    else $error("primary link word replaced before its ack returned");

  AST_SEC_TARGET_QUIET: assert property ( // [RULE14]
    !secondary_controller_select |=> !sec_fsync_int_o && !sec_bclk_int_o)
    else $error("secondary drives clocks in target mode");

  COV_PRI_FRAME: cover property ($rose(pri_fsync_int_o));
  COV_SEC_INV_FRAME: cover property (cfg[1].inv && $rose(sec_fsync_int_o));
  COV_STOP: cover property ($rose(q.err_a[ACFC_ERR_STOP]));
  COV_ERR_READ: cover property (
    reg_req.rd && reg_req.addr == ACFC_ADDR_ERR_A ##1 reg_rdata != 8'h00);
  COV_EXT_HANDOVER: cover property ($changed(q.xreq[1]));

endmodule

// ### tb/acfc_bclk_model.sv
// Far end model: supplies the two external bit clocks
module acfc_bclk_model (
  // Run control
  input wire logic run,
  // Bit clocks towards the block
  output logic pri_bclk,
  output logic sec_bclk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pri_bclk = 1'b0;
    sec_bclk = 1'b0;
  end
  // Rests low when stopped; 12 ns period, phases unrelated to mclk
  always #6 pri_bclk = run ? ~pri_bclk : 1'b0;
  initial begin
    #1.7;
    forever #6 sec_bclk = run ? ~sec_bclk : 1'b0;
  end
endmodule

// ### tb/tb_acfc_frame_clock_ctrl.sv
// Testbench of the audio port frame clock control
module tb_acfc_frame_clock_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import acfc_pkg::*;
  localparam int STOP_N = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b1;
  logic pri_bclk, sec_bclk;
  logic [1:0] lk;
  acfc_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic [1:0] csel = 2'b00;
  acfc_err_in_t err_in = '0;
  logic aclk_src = 1'b0;
  logic aclk_run = 1'b1;
  logic [1:0] ac_cnt = 2'h0;
  logic [1:0] bclk_int, fs_int, fs_ext;
  logic [4:0] ev [6] = '{5'h08, 5'h18, 5'h04, 5'h02, 5'h01, 5'h00};
  logic [7:0] sv [6] = '{8'h10, 8'h00, 8'h08, 8'h04, 8'h80, 8'h00};
  int err_total = 0;
  int compares = 0;

  assign lk = {sec_bclk, pri_bclk};
  always #2.5 mclk = ~mclk;
  // Audio clock source keeps toggling unless a stop is wanted
  always @(posedge mclk) begin
    ac_cnt <= ac_cnt + 2'h1;
    if (aclk_run && ac_cnt == 2'h3) aclk_src <= ~aclk_src;
  end

  acfc_bclk_model acfc_bclk_model_i (.run(run), .pri_bclk(pri_bclk),
    .sec_bclk(sec_bclk));
  acfc_frame_clock_ctrl #(.STOP_CYCLES(STOP_N)) acfc_frame_clock_ctrl_i (
    .mclk(mclk), .rst(rst), .pri_bclk(pri_bclk), .sec_bclk(sec_bclk),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .primary_controller_select(csel[0]),
    .secondary_controller_select(csel[1]),
    .err_in(err_in), .aclk_src(aclk_src),
    .pri_bclk_int_o(bclk_int[0]), .sec_bclk_int_o(bclk_int[1]),
    .pri_fsync_int_o(fs_int[0]), .sec_fsync_int_o(fs_int[1]),
    .pri_fsync_ext_o(fs_ext[0]), .sec_fsync_ext_o(fs_ext[1]));

  task automatic complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk);
    reg_req <= '0;
  endtask

  // Read and compare; the answer is awaited for a bounded number of edges
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge mclk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    reg_req <= '0;
    #1;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 3) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (reg_rvalid !== 1'b1) begin
      err_total++;
      complete_run();
    end else begin
      chk(reg_rdata, exp);
    end
  endtask

  // Internal then external sync generation of one port
  task automatic port_run(input int p, input logic inv);
    logic [7:0] b;
    logic pf, pb, pl;
    int last, highs, bad, guard;
    b = p ? ACFC_ADDR_SEC_HI : ACFC_ADDR_PRI_HI;
    wr(b + 8'h01, 8'h03);
    wr(b, {1'b1, inv, 6'h00});
    // The link side must first see the old external setting withdrawn
    repeat (40) @(posedge mclk);
    #1;
    pf = fs_int[p];
    pb = bclk_int[p];
    last = -1;
    highs = 0;
    bad = 0;
    for (int i = 0; i < 72; i++) begin
      @(posedge mclk);
      #1;
      if (fs_int[p] === 1'b1) highs++;
      if (fs_ext[p] !== 1'b0) bad++;
      if (fs_int[p] === 1'b1 && pf === 1'b0) begin
        chk({pb, bclk_int[p]}, {inv, ~inv});
        if (last >= 0) chk(i - last, 6 * ACFC_INT_DIV);
        last = i;
      end
      pf = fs_int[p];
      pb = bclk_int[p];
    end
    chk(highs, 72 / 3);
    chk(bad, 0);
    wr(b, {1'b0, inv, 6'h00});
    wr(b + 8'h01, 8'h04);
    repeat (40) @(posedge mclk);
    pl = lk[p];
    pf = fs_ext[p];
    last = -1;
    highs = 0;
    guard = 0;
    for (int i = 0; i < 64;) begin
      guard++;
      if (guard > 400) begin
        err_total++;
        complete_run();
      end
      @(lk);
      if (lk[p] !== pl) begin
        pl = lk[p];
        i++;
        #1;
        if (fs_int[p] !== 1'b0 || bclk_int[p] !== 1'b0) bad++;
        if (pl === inv) chk(fs_ext[p], pf);
        if (fs_ext[p] === 1'b1) highs++;
        if (fs_ext[p] === 1'b1 && pf === 1'b0) begin
          if (last >= 0) chk(i - last, 8);
          last = i;
        end
        pf = fs_ext[p];
      end
    end
    chk(highs, 16);
    chk(bad, 0);
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 8'h38; a <= 8'h3D; a++) rdc(a[7:0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h38 + i[7:0], 8'hC3 ^ {2{i[3:0]}});
    end
    wr(ACFC_ADDR_ERR_A, 8'h00);
    wr(8'h40, 8'hFF);
    rdc(8'h40, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rdc(8'h38 + i[7:0], 8'hC3 ^ {2{i[3:0]}});
      wr(8'h38 + i[7:0], 8'h00);
    end
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk);
      err_in <= ev[k];
      rdc(ACFC_ADDR_ERR_A, sv[k]);
    end
    @(posedge mclk);
    csel <= 2'b01;
    wr(ACFC_ADDR_PRI_LO, 8'h01);
    rdc(ACFC_ADDR_ERR_A, 8'h80);
    wr(ACFC_ADDR_PRI_LO, 8'h02);
    rdc(ACFC_ADDR_ERR_A, 8'h00);
    @(posedge mclk);
    csel <= 2'b11;
    rdc(ACFC_ADDR_ERR_A, 8'h80);
    wr(ACFC_ADDR_SEC_LO, 8'h02);
    aclk_run <= 1'b0;
    rdc(ACFC_ADDR_ERR_A, 8'h00);
    repeat (6) @(posedge mclk);
    rdc(ACFC_ADDR_ERR_A, 8'h00);
    repeat (20) @(posedge mclk);
    rdc(ACFC_ADDR_ERR_A, 8'h02);
    wr(ACFC_ADDR_ERR_A, 8'h00);
    rdc(ACFC_ADDR_ERR_A, 8'h02);
    @(posedge mclk);
    aclk_run <= 1'b1;
    repeat (12) @(posedge mclk);
    rdc(ACFC_ADDR_ERR_A, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int v = 0; v < 2; v++) port_run(p, v[0]);
    end
    @(posedge mclk);
    csel <= 2'b00;
    wr(ACFC_ADDR_PRI_HI, 8'h80);
    repeat (40) @(posedge mclk);
    repeat (24) begin
      @(posedge mclk);
      #1;
      chk({bclk_int, fs_int, fs_ext}, 6'h00);
    end
    rdc(ACFC_ADDR_ERR_A, 8'h00);
    complete_run();
  end
endmodule
